// File: rbw_relay_board.sv
`timescale 1ns/10ps
module rbw_relay_board #(
    parameter logic [rbw_pkg::WDOG_CNT_W-1:0] WDOG_TRIP_CYCLES = rbw_pkg::WDOG_TRIP_CYCLES
) (
    // clock and reset
    input  wire logic                         mclk_in,
    input  wire logic                         sys_rst_in,
    // avalon-mm register bus
    input  wire logic [rbw_pkg::ADDR_W-1:0]   avs_address_in,
    input  wire logic                         avs_read_in,
    input  wire logic                         avs_write_in,
    input  wire logic [rbw_pkg::DATA_W-1:0]   avs_writedata_in,
    output logic      [rbw_pkg::DATA_W-1:0]   avs_readdata_out,
    output logic                              avs_waitrequest_out,
    // interrupt
    output logic                              irq_out,
    // switched outputs
    output logic                              wheel_heat_out,
    output logic                              bench_elem_low_out,
    output logic                              bench_elem_high_out,
    output logic                              sample_cal_valve_out,
    output logic                              zero_span_valve_out,
    output logic                              shutoff_valve_out,
    output logic                              ir_source_out,
    // status indicators
    output logic                              watchdog_indicator_out,
    output logic                              wheel_heat_indicator_out,
    output logic                              bench_heat_indicator_out,
    output logic                              spare_indicator_out,
    output logic                              sample_cal_indicator_out,
    output logic                              zero_span_indicator_out,
    output logic                              shutoff_valve_indicator_out,
    output logic                              ir_source_indicator_out
);
    import rbw_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic              tripped;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        logic              irq;
        logic              wheel;
        logic              elem_low;
        logic              elem_high;
        logic              samp_cal;
        logic              zero_span;
        logic              shutoff;
        logic              ir_src;
        logic              wdog_led;
        logic              bench_led;
        logic              spare_led;
    } rbw_top_s;

    rbw_top_s s_r;
    rbw_top_s s_nxt;

    rbw_regbus_if rb ();

    logic wdog_toggle;
    logic wdog_trip;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    // host commands arrive as register writes over the bus
    rbw_avmm_slave u_slave (
        .mclk_in             (mclk_in),
        .sys_rst_in          (sys_rst_in),
        .avs_address_in      (avs_address_in),
        .avs_read_in         (avs_read_in),
        .avs_write_in        (avs_write_in),
        .avs_writedata_in    (avs_writedata_in),
        .avs_readdata_out    (avs_readdata_out),
        .avs_waitrequest_out (avs_waitrequest_out),
        .rb                  (rb.slave_side)
    );

    // stall detector on the host-driven watchdog level
    rbw_trip_timer #(
        .TRIP_CYCLES (WDOG_TRIP_CYCLES)
    ) u_timer (
        .mclk_in       (mclk_in),
        .sys_rst_in    (sys_rst_in),
        .wdog_level_in (s_r.ctrl[CTRL_WDOG_BIT]),
        .toggle_out    (wdog_toggle),
        .trip_out      (wdog_trip)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // bench element choice from line voltage code
    function automatic logic rbw_high_elem(input logic [1:0] volt);
        return (volt == VOLT_230);
    endfunction

    // read mux
    always_comb begin
        rb.rdata = '0;
        unique case (rb.addr)
            CTRL_OFS:     rb.rdata[CTRL_W-1:0] = s_r.ctrl;
            STATUS_OFS:   rb.rdata[STAT_WDOG_BIT:STAT_TRIPPED_BIT] =
                              {s_r.ctrl[CTRL_WDOG_BIT], s_r.tripped};
            IRQ_STAT_OFS: rb.rdata[IRQ_W-1:0] = s_r.irq_stat;
            IRQ_MASK_OFS: rb.rdata[IRQ_W-1:0] = s_r.irq_mask;
            default:      rb.rdata = '0;
        endcase
    end

    // ------------------------------------------------------------
    // register file and output logic
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // command decode from host writes
        if (rb.wr && rb.addr == CTRL_OFS) begin
            s_nxt.ctrl = rb.wdata[CTRL_W-1:0];
        end
        if (rb.wr && rb.addr == IRQ_MASK_OFS) begin
            s_nxt.irq_mask = rb.wdata[IRQ_W-1:0];
        end
        // trip clears switched outputs only, watchdog bit and voltage code untouched
        if (wdog_trip) begin
            s_nxt.ctrl    = s_nxt.ctrl & ~CTRL_TRIP_CLR;
            s_nxt.tripped = 1'b1;
        end else if (wdog_toggle) begin
            s_nxt.tripped = 1'b0;
        end
        // sticky events, read clears, set wins
        if (rb.rd && rb.addr == IRQ_STAT_OFS) begin
            s_nxt.irq_stat = '0;
        end
        if (wdog_trip) begin
            s_nxt.irq_stat[IRQ_TRIP_BIT] = 1'b1;
        end
        if (wdog_toggle) begin
            s_nxt.irq_stat[IRQ_TOGGLE_BIT] = 1'b1;
        end
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
        // registered drives follow the control bits
        s_nxt.wheel     = s_r.ctrl[CTRL_WHEEL_BIT];
        s_nxt.elem_low  = s_r.ctrl[CTRL_BENCH_BIT]
                          && !rbw_high_elem(s_r.ctrl[CTRL_VOLT_LSB+:2]);
        s_nxt.elem_high = s_r.ctrl[CTRL_BENCH_BIT]
                          && rbw_high_elem(s_r.ctrl[CTRL_VOLT_LSB+:2]);
        s_nxt.samp_cal  = s_r.ctrl[CTRL_SAMPCAL_BIT];
        s_nxt.zero_span = s_r.ctrl[CTRL_ZEROSPAN_BIT];
        s_nxt.shutoff   = s_r.ctrl[CTRL_SHUTOFF_BIT];
        s_nxt.ir_src    = s_r.ctrl[CTRL_IRSRC_BIT];
        s_nxt.wdog_led  = s_r.ctrl[CTRL_WDOG_BIT];
        // indicator flops, lit with either bench element
        s_nxt.bench_led = s_r.ctrl[CTRL_BENCH_BIT];
        s_nxt.spare_led = 1'b0;
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            s_r          <= '0;
            s_r.ctrl     <= CTRL_RST;
            s_r.irq_mask <= IRQ_MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // output assignment
    // ------------------------------------------------------------
    assign irq_out                     = s_r.irq;
    assign wheel_heat_out              = s_r.wheel;
    assign bench_elem_low_out          = s_r.elem_low;
    assign bench_elem_high_out         = s_r.elem_high;
    assign sample_cal_valve_out        = s_r.samp_cal;
    assign zero_span_valve_out         = s_r.zero_span;
    assign shutoff_valve_out           = s_r.shutoff;
    assign ir_source_out               = s_r.ir_src;
    // indicators mirror their outputs; watchdog, bench and spare come from their own flops
    assign watchdog_indicator_out      = s_r.wdog_led;
    assign wheel_heat_indicator_out    = s_r.wheel;
    assign bench_heat_indicator_out    = s_r.bench_led;
    assign spare_indicator_out         = s_r.spare_led;
    assign sample_cal_indicator_out    = s_r.samp_cal;
    assign zero_span_indicator_out     = s_r.zero_span;
    assign shutoff_valve_indicator_out = s_r.shutoff;
    assign ir_source_indicator_out     = s_r.ir_src;
endmodule

// File: rbw_pkg.sv
package rbw_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFS     = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFS   = 4'h4;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 4'hC;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_WDOG_BIT     = 0;
    localparam int CTRL_WHEEL_BIT    = 1;
    localparam int CTRL_BENCH_BIT    = 2;
    localparam int CTRL_SAMPCAL_BIT  = 3;
    localparam int CTRL_ZEROSPAN_BIT = 4;
    localparam int CTRL_SHUTOFF_BIT  = 5;
    localparam int CTRL_IRSRC_BIT    = 6;
    localparam int CTRL_VOLT_LSB     = 8;
    localparam int CTRL_W            = 10;
    localparam logic [CTRL_W-1:0] CTRL_RST      = 10'h040;
    // all switched outputs: heaters, valves, ir source
    localparam logic [CTRL_W-1:0] CTRL_TRIP_CLR = 10'h07E;

    // line voltage codes
    localparam logic [1:0] VOLT_100 = 2'h0;
    localparam logic [1:0] VOLT_115 = 2'h1;
    localparam logic [1:0] VOLT_230 = 2'h2;

    // ------------------------------------------------------------
    // status and interrupt fields
    // ------------------------------------------------------------
    localparam int STAT_TRIPPED_BIT = 0;
    localparam int STAT_WDOG_BIT    = 1;
    localparam int IRQ_TRIP_BIT     = 0;
    localparam int IRQ_TOGGLE_BIT   = 1;
    localparam int IRQ_W            = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ      = 64'd200_000_000;
    localparam longint WDOG_TRIP_S = 64'd30;
    localparam int     WDOG_CNT_W  = 33;
    localparam logic [WDOG_CNT_W-1:0] WDOG_TRIP_CYCLES =
        WDOG_CNT_W'(WDOG_TRIP_S * CLK_HZ);

endpackage

// File: rbw_regbus_if.sv
`timescale 1ns/10ps
// internal register access between bus slave and register file
interface rbw_regbus_if;
    import rbw_pkg::*;
    logic                  wr;
    logic                  rd;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
    logic [DATA_W-1:0]     rdata;

    modport slave_side (output wr, output rd, output addr, output wdata, input rdata);
    modport reg_side   (input wr, input rd, input addr, input wdata, output rdata);
endinterface

// File: rbw_avmm_slave.sv
`timescale 1ns/10ps
module rbw_avmm_slave (
    // clock and reset
    input  wire logic                         mclk_in,
    input  wire logic                         sys_rst_in,
    // avalon-mm slave
    input  wire logic [rbw_pkg::ADDR_W-1:0]   avs_address_in,
    input  wire logic                         avs_read_in,
    input  wire logic                         avs_write_in,
    input  wire logic [rbw_pkg::DATA_W-1:0]   avs_writedata_in,
    output logic      [rbw_pkg::DATA_W-1:0]   avs_readdata_out,
    output logic                              avs_waitrequest_out,
    // register side
    rbw_regbus_if.slave_side                  rb
);
    import rbw_pkg::*;

    typedef enum logic {SLV_IDLE, SLV_ANSWER} rbw_slv_e;

    typedef struct packed {
        rbw_slv_e          st;
        logic              wait_rq;
        logic [DATA_W-1:0] rdata;
    } rbw_slv_s;

    rbw_slv_s s_r;
    rbw_slv_s s_nxt;
    logic     accept;

    // request taken on the first edge it is seen; answered one cycle later
    assign accept   = (s_r.st == SLV_IDLE) && (avs_read_in || avs_write_in);
    assign rb.wr    = accept && avs_write_in;
    assign rb.rd    = accept && avs_read_in;
    assign rb.addr  = avs_address_in;
    assign rb.wdata = avs_writedata_in;

    // handshake sequencing
    always_comb begin
        s_nxt = s_r;
        unique case (s_r.st)
            SLV_IDLE: begin
                if (accept) begin
                    s_nxt.st      = SLV_ANSWER;
                    s_nxt.wait_rq = 1'b0;
                    s_nxt.rdata   = avs_read_in ? rb.rdata : '0;
                end
            end
            SLV_ANSWER: begin
                s_nxt.st      = SLV_IDLE;
                s_nxt.wait_rq = 1'b1;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            s_r <= '{st: SLV_IDLE, wait_rq: 1'b1, rdata: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata_out    = s_r.rdata;
    assign avs_waitrequest_out = s_r.wait_rq;
endmodule

// File: rbw_trip_timer.sv
`timescale 1ns/10ps
module rbw_trip_timer #(
    parameter logic [rbw_pkg::WDOG_CNT_W-1:0] TRIP_CYCLES = rbw_pkg::WDOG_TRIP_CYCLES
) (
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic sys_rst_in,
    // watchdog level and result
    input  wire logic wdog_level_in,
    output logic      toggle_out,
    output logic      trip_out
);
    import rbw_pkg::*;

    typedef struct packed {
        logic                  last;
        logic                  armed;
        logic                  toggle;
        logic                  trip;
        logic [WDOG_CNT_W-1:0] cnt;
    } rbw_tmr_s;

    rbw_tmr_s s_r;
    rbw_tmr_s s_nxt;

    // time since the indicator last changed level
    always_comb begin
        s_nxt        = s_r;
        s_nxt.last   = wdog_level_in;
        s_nxt.toggle = 1'b0;
        s_nxt.trip   = 1'b0;
        if (wdog_level_in != s_r.last) begin
            s_nxt.cnt    = '0;
            s_nxt.armed  = 1'b1;
            s_nxt.toggle = 1'b1;
        end else if (s_r.armed) begin
            if (s_r.cnt == TRIP_CYCLES - 1'b1) begin
                s_nxt.trip  = 1'b1;
                s_nxt.armed = 1'b0;                  // one trip per stall
            end else begin
                s_nxt.cnt = s_r.cnt + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            s_r <= '{last: 1'b0, armed: 1'b1, toggle: 1'b0, trip: 1'b0, cnt: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign toggle_out = s_r.toggle;
    assign trip_out   = s_r.trip;
endmodule

// File: rbw_properties.sv
`timescale 1ns/10ps
module rbw_properties #(
    parameter logic [rbw_pkg::WDOG_CNT_W-1:0] WDOG_TRIP_CYCLES = 33'd20
) (
    // clock and reset
    input wire logic                       mclk_in,
    input wire logic                       sys_rst_in,
    // register bus
    input wire logic [rbw_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic                       avs_read_in,
    input wire logic                       avs_write_in,
    input wire logic [rbw_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [rbw_pkg::DATA_W-1:0] avs_readdata_out,
    input wire logic                       avs_waitrequest_out,
    // switched outputs
    input wire logic                       wheel_heat_out,
    input wire logic                       bench_elem_low_out,
    input wire logic                       bench_elem_high_out,
    input wire logic                       sample_cal_valve_out,
    input wire logic                       zero_span_valve_out,
    input wire logic                       shutoff_valve_out,
    input wire logic                       ir_source_out,
    // indicators
    input wire logic                       watchdog_indicator_out,
    input wire logic                       wheel_heat_indicator_out,
    input wire logic                       bench_heat_indicator_out,
    input wire logic                       spare_indicator_out,
    input wire logic                       sample_cal_indicator_out,
    input wire logic                       zero_span_indicator_out,
    input wire logic                       shutoff_valve_indicator_out,
    input wire logic                       ir_source_indicator_out
);
    import rbw_pkg::*;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    // cycles since the watchdog indicator last moved
    logic [WDOG_CNT_W-1:0] still_r;
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || $changed(watchdog_indicator_out)) begin
            still_r <= '0;
        end else if (still_r != '1) begin
            still_r <= still_r + 1'b1;
        end
    end
    // bus request, its one-cycle answer, a taken control write
    sequence s_req; $rose(avs_read_in || avs_write_in); endsequence
    sequence s_ack; !avs_waitrequest_out ##1 avs_waitrequest_out; endsequence
    sequence s_ctrl_wr; !avs_waitrequest_out && avs_write_in && avs_address_in == CTRL_OFS; endsequence
    a_bus_answer: assert property (s_req |=> s_ack)
        else $error("answer not one cycle after request");
    a_ctrl_drives: assert property (s_ctrl_wr |=> watchdog_indicator_out == $past(avs_writedata_in[0])
        && wheel_heat_out == $past(avs_writedata_in[1]) && ir_source_out == $past(avs_writedata_in[6]))
        else $error("outputs do not follow control write");
    a_unmapped_zero: assert property (!avs_waitrequest_out && avs_read_in && avs_address_in[1:0] != 2'h0
        |-> avs_readdata_out == '0) else $error("unmapped read not zero");
    a_heat_ind: assert property (wheel_heat_indicator_out == wheel_heat_out
        && bench_heat_indicator_out == (bench_elem_low_out || bench_elem_high_out))
        else $error("heater indicator mismatch");
    a_spare_dark: assert property (!spare_indicator_out)
        else $error("spare indicator lit");
    a_valve_ind: assert property (sample_cal_indicator_out == sample_cal_valve_out
        && zero_span_indicator_out == zero_span_valve_out) else $error("valve indicator mismatch");
    a_shutoff_ind: assert property (shutoff_valve_indicator_out == shutoff_valve_out)
        else $error("shutoff indicator mismatch");
    a_ir_ind: assert property (ir_source_indicator_out == ir_source_out)
        else $error("ir source indicator mismatch");
    a_one_element: assert property (!(bench_elem_low_out && bench_elem_high_out))
        else $error("both bench elements on");
    a_trip_off: assert property (still_r == WDOG_TRIP_CYCLES + 4 |-> !(wheel_heat_out || bench_elem_low_out
        || bench_elem_high_out || sample_cal_valve_out || zero_span_valve_out || shutoff_valve_out || ir_source_out))
        else $error("outputs still on after watchdog stall");
endmodule
bind rbw_relay_board rbw_properties #(.WDOG_TRIP_CYCLES(WDOG_TRIP_CYCLES)) chk_u (.*);

// File: rbw_host_model.sv
`timescale 1ns/10ps
module rbw_host_model (
    // clock
    input  wire logic                       mclk_in,
    // avalon-mm master
    output logic      [rbw_pkg::ADDR_W-1:0] addr_out,
    output logic                            read_out,
    output logic                            write_out,
    output logic      [rbw_pkg::DATA_W-1:0] wdata_out,
    input  wire logic [rbw_pkg::DATA_W-1:0] readdata_in,
    input  wire logic                       waitrequest_in
);
    import rbw_pkg::*;
    // idle bus at time zero
    initial begin
        addr_out = '0;
        read_out = 1'b0;
        write_out = 1'b0;
        wdata_out = '0;
    end
    // one command, held until waitrequest is sampled low
    task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
        @(posedge mclk_in);
        addr_out <= a;
        wdata_out <= d;
        read_out <= rd;
        write_out <= !rd;
        @(posedge mclk_in);
        while (waitrequest_in !== 1'b0) @(posedge mclk_in);
        q = readdata_in;
        read_out <= 1'b0;
        write_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
endmodule

// File: rbw_relay_board_bench.sv
`timescale 1ns/10ps
module rbw_relay_board_bench;
    import rbw_pkg::*;
    localparam logic [WDOG_CNT_W-1:0] TRIP = 33'd200;
    logic mclk_in = 1'b0, sys_rst_in = 1'b1;
    logic [ADDR_W-1:0] avs_address_in;
    logic [DATA_W-1:0] avs_writedata_in, avs_readdata_out, q;
    logic avs_read_in, avs_write_in, avs_waitrequest_out, irq_out;
    logic wheel_heat_out, bench_elem_low_out, bench_elem_high_out, sample_cal_valve_out;
    logic zero_span_valve_out, shutoff_valve_out, ir_source_out, watchdog_indicator_out;
    logic wheel_heat_indicator_out, bench_heat_indicator_out, spare_indicator_out, sample_cal_indicator_out;
    logic zero_span_indicator_out, shutoff_valve_indicator_out, ir_source_indicator_out;
    int miscompares = 0, checked = 0, cycles = 0;
    int ctrl_m = 'h040, irq_m = 0, mask_m = 0, trip_m = 0;
    integer seed = 32'h0ec05ac6;

    always #2.5 mclk_in = ~mclk_in;
    rbw_relay_board #(.WDOG_TRIP_CYCLES(TRIP)) dut_u (.*);
    rbw_host_model host_u (.mclk_in(mclk_in), .addr_out(avs_address_in), .read_out(avs_read_in),
        .write_out(avs_write_in), .wdata_out(avs_writedata_in), .readdata_in(avs_readdata_out),
        .waitrequest_in(avs_waitrequest_out));

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // write through the host, model kept in step
    task automatic wr(input logic [ADDR_W-1:0] a, input int d);
        host_u.xfer(1'b0, a, DATA_W'(d), q);
        if (a == CTRL_OFS && ((d ^ ctrl_m) & 1)) begin
            irq_m |= 2;
            trip_m = 0;
        end
        if (a == CTRL_OFS) ctrl_m = d & 'h3ff;
        if (a == IRQ_MASK_OFS) mask_m = d & 3;
    endtask
    // read compared with the model; status of interrupts clears
    task automatic rd(input logic [ADDR_W-1:0] a);
        int e;
        e = (a == CTRL_OFS) ? ctrl_m : (a == STATUS_OFS) ? ((ctrl_m & 1) << 1 | trip_m)
          : (a == IRQ_STAT_OFS) ? irq_m : (a == IRQ_MASK_OFS) ? mask_m : 0;
        host_u.xfer(1'b1, a, '0, q);
        chk(q, e);
        if (a == IRQ_STAT_OFS) irq_m = 0;
    endtask
    // outputs, indicators and interrupt a cycle after the answer
    task automatic outs();
        int v, lo, hi;
        @(posedge mclk_in);
        #1;
        v = ctrl_m;
        hi = (v >> 2 & 1) & ((v >> 8) == 2);
        lo = (v >> 2 & 1) & ((v >> 8) != 2);
        chk({wheel_heat_out, bench_elem_low_out, bench_elem_high_out, sample_cal_valve_out, zero_span_valve_out,
             shutoff_valve_out, ir_source_out}, {v[1], lo[0], hi[0], v[3], v[4], v[5], v[6]});
        chk({watchdog_indicator_out, wheel_heat_indicator_out, bench_heat_indicator_out, spare_indicator_out,
             sample_cal_indicator_out, zero_span_indicator_out, shutoff_valve_indicator_out,
             ir_source_indicator_out}, {v[0], v[1], v[2], 1'b0, v[3], v[4], v[5], v[6]});
        chk(irq_out, (irq_m & mask_m) != 0);
    endtask

    // hang guard
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            results();
        end
    end

    initial begin
        repeat (8) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        outs();
        // reset values and every address, unmapped ones read zero
        for (int a = 0; a < 16; a++) rd(a[3:0]);
        wr(STATUS_OFS, 3);
        wr(4'h2, 'hff);
        rd(STATUS_OFS);
        wr(IRQ_MASK_OFS, 3);
        // random control words over all voltage codes, watchdog toggled each time
        for (int i = 0; i < 12; i++) begin
            wr(CTRL_OFS, ($random(seed) & 'hfe) | (i % 3) << 8 | (~ctrl_m & 1));
            outs();
            if (i % 4 == 1) rd(CTRL_OFS);
            if (i % 4 == 3) rd(IRQ_STAT_OFS);
            if (i == 6) wr(IRQ_MASK_OFS, 0);
        end
        // stall the watchdog with everything on
        wr(IRQ_MASK_OFS, 1);
        wr(CTRL_OFS, 'h27e | (~ctrl_m & 1));
        outs();
        repeat (TRIP + 10) @(posedge mclk_in);
        ctrl_m &= 'h381;
        trip_m = 1;
        irq_m |= 1;
        outs();
        rd(STATUS_OFS);
        rd(CTRL_OFS);
        rd(IRQ_STAT_OFS);
        outs();
        // a toggle alone restores nothing, a rewrite does
        wr(CTRL_OFS, ctrl_m ^ 1);
        outs();
        rd(STATUS_OFS);
        wr(CTRL_OFS, 'h17e | (~ctrl_m & 1));
        outs();
        // reset in mid-run brings back the defaults
        @(posedge mclk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        ctrl_m = 'h040;
        irq_m = 0;
        mask_m = 0;
        trip_m = 0;
        @(posedge mclk_in);
        outs();
        rd(STATUS_OFS);
        rd(IRQ_STAT_OFS);
        results();
    end
endmodule
